// ---- ats_cpu_model.sv ----
// far side: the watch crystal on the pin and the core taking vectors
// assumes mclk is much faster than the crystal
`timescale 1ns/100ps
`default_nettype none
module ats_cpu_model
  import ats_pkg::*;
#(
  parameter realtime OSC_HALF = 41.0
)
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic oscEn,
  input  wire logic ackEn,
  input  wire logic irqOvf,
  input  wire logic irqCmpA,
  input  wire logic irqCmpB,
  output logic      oscClockIn,
  output logic      vecOvf,
  output logic      vecCmpA,
  output logic      vecCmpB
);
  // crystal halts in deep sleep, pin then keeps its last level
  initial begin
    oscClockIn = 1'b0;
    forever begin
      #(OSC_HALF);
      if (oscEn) begin
        oscClockIn = ~oscClockIn;
      end
    end
  end
  // one-cycle vector pulse; a repeat while irq lags is harmless
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vecOvf  <= 1'b0;
      vecCmpA <= 1'b0;
      vecCmpB <= 1'b0;
    end else begin
      vecOvf  <= ackEn && irqOvf && !vecOvf;
      vecCmpA <= ackEn && irqCmpA && !vecCmpA;
      vecCmpB <= ackEn && irqCmpB && !vecCmpB;
    end
  end
endmodule
`default_nettype wire

// ---- ats_pkg.sv ----
// constants for the asynchronous timer support block
// assumes a byte-wide register file behind a 32-bit classic wishbone port
package ats_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADR_W  = 10;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS  = 8'h17;
  localparam logic [7:0] IDX_MASK   = 8'h70;
  localparam logic [7:0] IDX_CTRL_A = 8'hB0;
  localparam logic [7:0] IDX_CTRL_B = 8'hB1;
  localparam logic [7:0] IDX_COUNT  = 8'hB2;
  localparam logic [7:0] IDX_CMP_A  = 8'hB3;
  localparam logic [7:0] IDX_CMP_B  = 8'hB4;
  localparam logic [7:0] IDX_ASYNC  = 8'hB6;

  // holding slots; slot number equals its busy bit in async status
  localparam int unsigned NUM_SLOTS   = 5;
  localparam int unsigned SLOT_CTRL_B = 0;
  localparam int unsigned SLOT_CTRL_A = 1;
  localparam int unsigned SLOT_CMP_B  = 2;
  localparam int unsigned SLOT_CMP_A  = 3;
  localparam int unsigned SLOT_COUNT  = 4;

  // async status and flag/mask bit positions
  localparam int unsigned BIT_ASYNC_SEL = 5;
  localparam int unsigned BIT_EXT_CLK   = 6;
  localparam int unsigned BIT_OVF       = 0;
  localparam int unsigned BIT_CMP_A     = 1;
  localparam int unsigned BIT_CMP_B     = 2;
  localparam int unsigned NUM_FLAGS     = 3;

  localparam logic [7:0] RST_VAL     = 8'h00;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  localparam logic [7:0] COUNT_BOT   = 8'h00;

  // timing counts
  localparam logic [1:0] XFER_EDGES       = 2'h2;
  localparam logic [1:0] FLAG_SYNC_CYCLES = 2'h3;
  localparam logic [2:0] WAKE_HALT_CYCLES = 3'h4;

  // sleep mode codes from the power manager
  localparam logic [2:0] SLP_NONE       = 3'h0;
  localparam logic [2:0] SLP_IDLE       = 3'h1;
  localparam logic [2:0] SLP_NOISE_RED  = 3'h2;
  localparam logic [2:0] SLP_POWER_SAVE = 3'h3;
  localparam logic [2:0] SLP_POWER_DOWN = 3'h4;
  localparam logic [2:0] SLP_STANDBY    = 3'h5;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_HALT  = 3'b100
  } ats_wake_e;

endpackage

// ---- ats_timer_async.sv ----
// async-clock support for an 8-bit timer: holding registers, busy flags,
// counter read path, wake-up timing, interrupt flags and mask.
// assumes mclk is the i/o clock, well over four times the oscillator rate;
// the oscillator pin is sampled, not used as a clock.
`timescale 1ns/100ps
`default_nettype none

// Function
// - control-A write in async mode sets its busy bit until transferred.
// - control-B write in async mode sets its busy bit until transferred.
// - counter read gives the copy refreshed on oscillator rise; other four read their holding register (control-B bits 7:4 read zero).
// - written value held, then latched after two rising oscillator edges.
// - each of the five registers has its own holding register.
// - compare match suppressed while compare or counter write is pending.
// - interrupt logic needs one oscillator cycle to rearm after wake.
// - oscillator runs in all sleep modes except power-down and standby.
// - timer contents undefined after power-down or standby wake.
// - wake starts on the timer clock after the interrupt condition.
// - after timer wake the processor halts four cycles.
// - counter read through register refreshed on each rising oscillator edge.
// - async flag synchronisation takes three cycles plus one timer cycle.
// - compare output changes on the timer clock, not resynchronised.
// - compare interrupts need their enable, global enable and flag.
// - overflow interrupt needs overflow enable, global enable and flag.
// - compare-B flag sets on match, clears on vector or written one.
// - compare-A flag sets on match, clears on vector or written one.
// - overflow flag sets on overflow or phase-correct reversal at zero.
// - clock-select bit zero picks i/o clock, one picks the oscillator.
module ats_timer_async
  import ats_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              oscClockIn,
  input  wire logic              globalIrqEn,
  input  wire logic              vecTakenOvf,
  input  wire logic              vecTakenCmpA,
  input  wire logic              vecTakenCmpB,
  input  wire logic [2:0]        sleepMode,
  output logic                   irqOvf,
  output logic                   irqCmpA,
  output logic                   irqCmpB,
  output logic                   cmpOutA,
  output logic                   cmpOutB,
  output logic                   oscRun,
  output logic                   wakeReq,
  output logic                   cpuHalt
);

  // bus slave
  logic       busReq;
  logic       busWr;
  logic [7:0] busIdx;
  logic [7:0] wrByte;
  logic       ackQ;
  logic [7:0] rdData;

  assign busReq = wb_cyc_i & wb_stb_i & ~ackQ;
  assign busWr  = busReq & wb_we_i & wb_sel_i[0];
  assign busIdx = wb_adr_i[9:2];
  assign wrByte = wb_dat_i[7:0];

  // oscillator pin: three flops, a change counts when second and third agree
  logic [2:0] oscSync_q;
  logic       oscLvl_q;
  logic       oscRise;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oscSync_q <= 3'h0;
      oscLvl_q  <= 1'b0;
    end else begin
      oscSync_q <= {oscSync_q[1:0], oscClockIn};
      if (oscSync_q[1] == oscSync_q[2]) begin
        oscLvl_q <= oscSync_q[2];
      end
    end
  end

  // a stopped oscillator gives no edges, so timer state freezes
  assign oscRise = oscRun & ~oscLvl_q & oscSync_q[1] & oscSync_q[2];

  // registers written directly from the bus
  logic [7:0] mask_q;
  logic       asyncSel_q;
  logic       extClk_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q     <= RST_VAL;
      asyncSel_q <= 1'b0;
      extClk_q   <= 1'b0;
    end else if (busWr && busIdx == IDX_MASK) begin
      mask_q <= {5'h00, wrByte[NUM_FLAGS-1:0]};
    end else if (busWr && busIdx == IDX_ASYNC) begin
      asyncSel_q <= wrByte[BIT_ASYNC_SEL];
      extClk_q   <= wrByte[BIT_EXT_CLK];
    end
  end

  // oscillator runs only in async mode and stops in power-down and standby
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oscRun <= 1'b0;
    end else begin
      oscRun <= asyncSel_q & (sleepMode != SLP_POWER_DOWN) &
                (sleepMode != SLP_STANDBY);
    end
  end

  // timer tick: every i/o clock, or each oscillator rising edge
  logic tick;
  assign tick = asyncSel_q ? oscRise : 1'b1;

  // per-register holding registers and transfer sequencing
  logic [7:0] hold_q  [NUM_SLOTS];
  logic [1:0] phase_q [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] pend_q;
  logic [NUM_SLOTS-1:0] wrSlot;
  logic [NUM_SLOTS-1:0] xfer;
  logic [7:0] xferVal [NUM_SLOTS];

  assign wrSlot[SLOT_CTRL_B] = busWr && busIdx == IDX_CTRL_B;
  assign wrSlot[SLOT_CTRL_A] = busWr && busIdx == IDX_CTRL_A;
  assign wrSlot[SLOT_CMP_B]  = busWr && busIdx == IDX_CMP_B;
  assign wrSlot[SLOT_CMP_A]  = busWr && busIdx == IDX_CMP_A;
  assign wrSlot[SLOT_COUNT]  = busWr && busIdx == IDX_COUNT;

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
      // a fresh write restarts the transfer and wins over completion
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          hold_q[gs]  <= RST_VAL;
          phase_q[gs] <= 2'h0;
          pend_q[gs]  <= 1'b0;
        end else if (wrSlot[gs]) begin
          hold_q[gs]  <= wrByte;
          phase_q[gs] <= 2'h0;
          pend_q[gs]  <= asyncSel_q;
        end else if (pend_q[gs] && oscRise) begin
          phase_q[gs] <= phase_q[gs] + 2'h1;
          if (phase_q[gs] == XFER_EDGES - 2'h1) begin
            pend_q[gs] <= 1'b0;
          end
        end
      end
      // second rising edge latches the held value
      assign xfer[gs] = asyncSel_q ?
        (pend_q[gs] & oscRise & ~wrSlot[gs] &
         (phase_q[gs] == XFER_EDGES - 2'h1)) : wrSlot[gs];
      assign xferVal[gs] = asyncSel_q ? hold_q[gs] : wrByte;
    end
  endgenerate

  // destination registers in the timer domain
  logic [7:0] ctrlA_q;
  logic [7:0] ctrlB_q;
  logic [7:0] cmpA_q;
  logic [7:0] cmpB_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlA_q <= RST_VAL;
      ctrlB_q <= RST_VAL;
      cmpA_q  <= RST_VAL;
      cmpB_q  <= RST_VAL;
    end else begin
      if (xfer[SLOT_CTRL_A]) ctrlA_q <= xferVal[SLOT_CTRL_A];
      if (xfer[SLOT_CTRL_B]) ctrlB_q <= xferVal[SLOT_CTRL_B];
      if (xfer[SLOT_CMP_A])  cmpA_q  <= xferVal[SLOT_CMP_A];
      if (xfer[SLOT_CMP_B])  cmpB_q  <= xferVal[SLOT_CMP_B];
    end
  end

  // counter: normal wrap, ctc, or phase-correct up/down
  logic [7:0] count_q;
  logic       countDown_q;
  logic       blockNext_q;
  logic       tickRun;
  logic       phaseCorrect;
  logic [7:0] topVal;
  logic       ovfEv;
  logic       matchA;
  logic       matchB;

  assign tickRun      = tick & (ctrlB_q[2:0] != 3'h0);
  assign phaseCorrect = ctrlA_q[1:0] == 2'h1;
  assign topVal       = (ctrlB_q[3] || ctrlA_q[1:0] == 2'h2) ?
                        cmpA_q : COUNT_MAX;
  assign ovfEv = tickRun & ~xfer[SLOT_COUNT] & (phaseCorrect ?
                 (countDown_q && count_q == COUNT_BOT) :
                 (count_q == COUNT_MAX));

  // no match while a compare or counter write is in flight
  assign matchA = tickRun & ~blockNext_q & ~pend_q[SLOT_CMP_A] &
                  ~pend_q[SLOT_COUNT] & (count_q == cmpA_q);
  assign matchB = tickRun & ~blockNext_q & ~pend_q[SLOT_CMP_B] &
                  ~pend_q[SLOT_COUNT] & (count_q == cmpB_q);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q     <= RST_VAL;
      countDown_q <= 1'b0;
      blockNext_q <= 1'b0;
    end else if (xfer[SLOT_COUNT]) begin
      count_q     <= xferVal[SLOT_COUNT];
      blockNext_q <= 1'b1;
    end else if (tickRun) begin
      blockNext_q <= 1'b0;
      if (phaseCorrect) begin
        if (!countDown_q && count_q == topVal) begin
          countDown_q <= 1'b1;
          count_q     <= count_q - 8'h01;
        end else if (countDown_q && count_q == COUNT_BOT) begin
          countDown_q <= 1'b0;
          count_q     <= count_q + 8'h01;
        end else begin
          count_q <= countDown_q ? count_q - 8'h01 : count_q + 8'h01;
        end
      end else begin
        countDown_q <= 1'b0;
        count_q <= (count_q == topVal) ? COUNT_BOT : count_q + 8'h01;
      end
    end
  end

  // cpu-side copy of the counter, refreshed on each rising oscillator edge
  logic [7:0] countRd_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      countRd_q <= RST_VAL;
    end else if (!asyncSel_q || oscRise) begin
      countRd_q <= count_q;
    end
  end

  // compare outputs toggle straight from the timer tick, no resync
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmpOutA <= 1'b0;
      cmpOutB <= 1'b0;
    end else begin
      if (matchA && ctrlA_q[7:6] == 2'h1) cmpOutA <= ~cmpOutA;
      if (matchB && ctrlA_q[5:4] == 2'h1) cmpOutB <= ~cmpOutB;
    end
  end

  // flag events cross a three-stage pipe in async mode
  logic [NUM_FLAGS-1:0] evNow;
  logic [NUM_FLAGS-1:0] evDly_q [3];
  logic [NUM_FLAGS-1:0] flagSet;
  logic [NUM_FLAGS-1:0] flagClr;
  logic [NUM_FLAGS-1:0] vecTaken;
  logic [NUM_FLAGS-1:0] flags_q;

  assign evNow = {matchB, matchA, ovfEv};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evDly_q[0] <= 3'h0;
      evDly_q[1] <= 3'h0;
      evDly_q[2] <= 3'h0;
    end else begin
      evDly_q[0] <= asyncSel_q ? evNow : 3'h0;
      evDly_q[1] <= evDly_q[0];
      evDly_q[2] <= evDly_q[1];
    end
  end

  // FLAG_SYNC_CYCLES stages after the timer edge
  assign flagSet  = asyncSel_q ? evDly_q[FLAG_SYNC_CYCLES - 2'h1] : evNow;
  assign vecTaken = {vecTakenCmpB, vecTakenCmpA, vecTakenOvf};
  assign flagClr  = vecTaken |
    ((busWr && busIdx == IDX_FLAGS) ? wrByte[NUM_FLAGS-1:0] : 3'h0);

  genvar gf;
  generate
    for (gf = 0; gf < NUM_FLAGS; gf++) begin : g_flag
      // set beats a clear in the same cycle
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[gf] <= 1'b0;
        end else begin
          flags_q[gf] <= flagSet[gf] |
                         (flags_q[gf] & ~flagClr[gf]);
        end
      end
    end
  endgenerate

  // interrupt requests
  logic [NUM_FLAGS-1:0] irqPend;
  assign irqPend = flags_q & mask_q[NUM_FLAGS-1:0] & {NUM_FLAGS{globalIrqEn}};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqOvf  <= 1'b0;
      irqCmpA <= 1'b0;
      irqCmpB <= 1'b0;
    end else begin
      irqOvf  <= irqPend[BIT_OVF];
      irqCmpA <= irqPend[BIT_CMP_A];
      irqCmpB <= irqPend[BIT_CMP_B];
    end
  end

  // wake sequencing
  ats_wake_e  wake_q;
  logic       armed_q;
  logic [2:0] haltCnt_q;
  logic       wakeNow;

  // a condition raised while asleep is acted on at the next timer edge
  assign wakeNow = (wake_q == ST_SLEEP) & armed_q & (|irqPend) & tick;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_q    <= ST_RUN;
      haltCnt_q <= 3'h0;
      wakeReq   <= 1'b0;
      cpuHalt   <= 1'b0;
    end else begin
      wakeReq <= wakeNow;
      unique case (wake_q)
        ST_RUN: begin
          cpuHalt <= 1'b0;
          if (sleepMode != SLP_NONE) wake_q <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (wakeNow) begin
            wake_q    <= ST_HALT;
            haltCnt_q <= 3'h0;
            cpuHalt   <= 1'b1;
          end else if (sleepMode == SLP_NONE) begin
            wake_q <= ST_RUN;
          end
        end
        ST_HALT: begin
          haltCnt_q <= haltCnt_q + 3'h1;
          if (haltCnt_q == WAKE_HALT_CYCLES - 3'h1) begin
            cpuHalt <= 1'b0;
            wake_q  <= ST_RUN;
          end
        end
      endcase
    end
  end

  // after a wake further wake requests stay blocked until the next oscillator rise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b1;
    end else if (wakeNow) begin
      armed_q <= 1'b0;
    end else if (oscRise || !asyncSel_q) begin
      armed_q <= 1'b1;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case (busIdx)
      IDX_FLAGS:  rdData = {5'h00, flags_q};
      IDX_MASK:   rdData = mask_q;
      IDX_ASYNC:  rdData = {1'b0, extClk_q, asyncSel_q, pend_q};
      IDX_COUNT:  rdData = countRd_q;
      IDX_CTRL_A: rdData = hold_q[SLOT_CTRL_A];
      IDX_CTRL_B: rdData = {hold_q[SLOT_CTRL_B][7:6] & 2'h0, 2'h0,
                            hold_q[SLOT_CTRL_B][3:0]};
      IDX_CMP_A:  rdData = hold_q[SLOT_CMP_A];
      IDX_CMP_B:  rdData = hold_q[SLOT_CMP_B];
      default:    rdData = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ackQ     <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ackQ     <= busReq;
      wb_dat_o <= busReq ? {24'h00_0000, rdData} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ackQ;

endmodule

`default_nettype wire

// ---- ats_timer_async_sva.sv ----
// port assertions for the async timer support block
// assumes binding onto ats_timer_async, single mclk domain
`timescale 1ns/100ps
`default_nettype none
module ats_timer_async_sva
  import ats_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             globalIrqEn,
  input wire logic [2:0]       sleepMode,
  input wire logic             irqOvf,
  input wire logic             irqCmpA,
  input wire logic             irqCmpB,
  input wire logic             oscRun,
  input wire logic             wakeReq,
  input wire logic             cpuHalt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_halt;
    cpuHalt [*4] ##1 !cpuHalt;
  endsequence
  a_ack_next_cycle: assert property (s_req |=> wb_ack_o)
    else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ovf_irq_gated: assert property (!$past(globalIrqEn) |-> !irqOvf)
    else $error("ovf irq without enable");
  a_cmpa_irq_gated: assert property (!$past(globalIrqEn) |-> !irqCmpA)
    else $error("cmp a irq without enable");
  a_cmpb_irq_gated: assert property (!$past(globalIrqEn) |-> !irqCmpB)
    else $error("cmp b irq without enable");
  a_osc_stop_deep: assert property ((sleepMode == SLP_POWER_DOWN ||
    sleepMode == SLP_STANDBY) |=> !oscRun)
    else $error("oscillator left running");
  a_wake_one_pulse: assert property (wakeReq |=> !wakeReq)
    else $error("wake pulse too long");
  a_halt_four_cycles: assert property ($rose(cpuHalt) |-> s_halt)
    else $error("halt length wrong");
  a_wake_then_halt: assert property (wakeReq |-> ##[0:1] cpuHalt)
    else $error("no halt after wake");
endmodule
bind ats_timer_async ats_timer_async_sva u_ats_timer_async_sva (
  .mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .globalIrqEn,
  .sleepMode, .irqOvf, .irqCmpA, .irqCmpB, .oscRun, .wakeReq, .cpuHalt);
`default_nettype wire

// ---- test_ats_timer_async.sv ----
// self-checking bench for the async timer support block
// assumes package, design, cpu model and checker compiled before it
`timescale 1ns/100ps
`default_nettype none
module test_ats_timer_async;
  import ats_pkg::*;
  localparam int LIMIT = 60000;
  logic             mclk;
  logic             rst_n;
  logic             cyc;
  logic             stb;
  logic             we;
  logic [ADR_W-1:0] adr;
  logic [31:0]      datW;
  logic [31:0]      datR;
  logic [3:0]       sel;
  logic             ack;
  logic             gie;
  logic             ackEn;
  logic [2:0]       slp;
  logic             osc, oscRun, wake, halt, vO, vA, vB, iO, iA, iB;
  logic [7:0]       rv;
  logic [7:0]       rv2;
  logic             got;
  logic             cA, cB, oA0, oB0;
  int               errCount, cmpCount, cycles;
  logic [7:0]       slotIdx [5] = '{IDX_CTRL_B, IDX_CTRL_A, IDX_CMP_B,
                                    IDX_CMP_A, IDX_COUNT};
  logic [7:0]       slotVal [5] = '{8'h00, 8'h50, 8'h33, 8'h44, 8'h10};
  logic [7:0]       regIdx [8] = '{IDX_FLAGS, IDX_MASK, IDX_CTRL_A,
    IDX_CTRL_B, IDX_COUNT, IDX_CMP_A, IDX_CMP_B, IDX_ASYNC};

  ats_timer_async u_ats_timer_async (.mclk(mclk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(datW), .wb_sel_i(sel), .wb_dat_o(datR), .wb_ack_o(ack),
    .oscClockIn(osc), .globalIrqEn(gie), .vecTakenOvf(vO),
    .vecTakenCmpA(vA), .vecTakenCmpB(vB), .sleepMode(slp), .irqOvf(iO),
    .irqCmpA(iA), .irqCmpB(iB), .cmpOutA(cA), .cmpOutB(cB), .oscRun(oscRun),
    .wakeReq(wake), .cpuHalt(halt));
  ats_cpu_model u_ats_cpu_model (.mclk(mclk), .rst_n(rst_n),
    .oscEn(oscRun), .ackEn(ackEn), .irqOvf(iO), .irqCmpA(iA),
    .irqCmpB(iB), .oscClockIn(osc), .vecOvf(vO), .vecCmpA(vA),
    .vecCmpB(vB));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int k;
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    datW <= {24'h0, wd};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = datR[7:0];
    if (k >= 20) check("ack", 8'h01, 8'h00);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] d;
    bus(1'b1, idx, v, d);
  endtask

  task automatic rdChk(input string what, input logic [7:0] idx,
                       input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    check(what, exp, d);
  endtask

  // polls async status until the busy bits are gone, never writing meanwhile
  task automatic waitBusy;
    logic [7:0] d;
    int k;
    k = 0;
    do begin
      bus(1'b0, IDX_ASYNC, 8'h00, d);
      k++;
    end while (d[4:0] !== 5'h00 && k < 40);
    check("busy clear", 8'h00, {3'h0, d[4:0]});
    // counter copy only catches up on the next oscillator rise
    repeat (25) @(posedge mclk);
  endtask

  task automatic waitHigh(ref logic s, input int lim, output logic ok);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(posedge mclk);
      k++;
    end
    ok = (s === 1'b1);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errCount++;
      close_out();
    end
  end

  initial begin
    {cyc, stb, we, gie, ackEn} = 5'h00;
    adr   = '0;
    datW  = 32'h0;
    sel   = 4'h1;
    slp   = SLP_NONE;
    rst_n = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    foreach (regIdx[i]) rdChk("reset value", regIdx[i], RST_VAL);
    wr(8'h01, 8'hFF);
    rdChk("unmapped", 8'h01, 8'h00);
    wr(IDX_MASK, 8'hFF);
    rdChk("mask bits", IDX_MASK, 8'h07);
    wr(IDX_MASK, 8'h00);
    wr(IDX_CMP_A, 8'h5A);
    rdChk("sync no busy", IDX_ASYNC, 8'h00);
    rdChk("sync cmp a", IDX_CMP_A, 8'h5A);
    $display("registers and sync mode done");
    wr(IDX_ASYNC, 8'h20);
    foreach (slotIdx[i]) begin
      wr(slotIdx[i], slotVal[i]);
      rdChk("busy set", IDX_ASYNC, 8'h20 | (8'h01 << i));
      repeat (14) @(posedge mclk);
      rdChk("busy held", IDX_ASYNC, 8'h20 | (8'h01 << i));
      waitBusy();
      rdChk("holding", slotIdx[i], slotVal[i]);
    end
    wr(IDX_COUNT, 8'h20);
    wr(IDX_CMP_A, 8'h25);
    rdChk("two pending", IDX_ASYNC, 8'h38);
    waitBusy();
    rdChk("count", IDX_COUNT, 8'h20);
    rdChk("cmp a", IDX_CMP_A, 8'h25);
    wr(IDX_FLAGS, 8'h07);
    wr(IDX_CTRL_B, 8'h01);
    waitBusy();
    bus(1'b0, IDX_COUNT, 8'h00, rv);
    repeat (100) @(posedge mclk);
    bus(1'b0, IDX_COUNT, 8'h00, rv2);
    check("count moves", 8'h01, {7'h0, rv2 !== rv});
    $display("async holding done");
    wr(IDX_CMP_A, 8'h80);
    waitBusy();
    wr(IDX_FLAGS, 8'h02);
    oA0 = cA;
    wr(IDX_MASK, 8'h02);
    rv = 8'h00;
    for (int k = 0; k < 1500 && rv[1] !== 1'b1; k++)
      bus(1'b0, IDX_FLAGS, 8'h00, rv);
    check("cmp a flag", 8'h01, {7'h0, rv[1]});
    check("cmp out a", {7'h0, ~oA0}, {7'h0, cA});
    check("irq gated", 8'h00, {7'h0, iA});
    gie <= 1'b1;
    repeat (3) @(posedge mclk);
    check("irq cmp a", 8'h01, {7'h0, iA});
    wr(IDX_FLAGS, 8'h06);
    repeat (3) @(posedge mclk);
    check("irq cleared", 8'h00, {7'h0, iA});
    rdChk("w1c", IDX_FLAGS, 8'h00);
    ackEn <= 1'b1;
    wr(IDX_MASK, 8'h01);
    waitHigh(iO, 20000, got);
    check("irq ovf", 8'h01, {7'h0, got});
    repeat (6) @(posedge mclk);
    rdChk("vector clear", IDX_FLAGS, 8'h00);
    ackEn <= 1'b0;
    $display("interrupts done");
    wr(IDX_MASK, 8'h04);
    bus(1'b0, IDX_COUNT, 8'h00, rv);
    wr(IDX_CMP_B, rv + 8'h10);
    waitBusy();
    oB0 = cB;
    wr(IDX_FLAGS, 8'h07);
    slp <= SLP_POWER_SAVE;
    repeat (3) @(posedge mclk);
    check("osc in save", 8'h01, {7'h0, oscRun});
    waitHigh(wake, 4000, got);
    check("wake", 8'h01, {7'h0, got});
    check("cmp out b", {7'h0, ~oB0}, {7'h0, cB});
    slp <= SLP_NONE;
    wr(IDX_FLAGS, 8'h04);
    slp <= SLP_POWER_DOWN;
    repeat (3) @(posedge mclk);
    check("osc in down", 8'h00, {7'h0, oscRun});
    slp <= SLP_NONE;
    $display("sleep done");
    close_out();
  end
endmodule
`default_nettype wire
